// ### hdl/sgc_pkg.sv
// constants shared by the supply-gated channel configuration block
// assumes a 40 MHz ref_clk and an 8-bit register port in the same domain
// Notes on behaviour
// - bit 4 marks 12V channel; resets 0
// - bit 3 marks 5V channel; resets 0
// - bit 2 marks 3.3V channel; resets 0
// - bit 1 marks CPU core channel; resets 1
// - bit 0 marks 2.5V channel; resets 0
// - supply off: marked channels stop, status zero
// - resume marked channels 182 ms after supply
// - zone1 gain/offset correction register at 7dh
// - correction writes ignored while lock set
// - supply config at 79h, read-only when locked
package sgc_pkg;

   localparam int unsigned NUM_CH   = 5;
   localparam int unsigned STAT_W   = 4;

   // register offsets
   localparam logic [7:0] CHAN_SUPPLY_CFG_OFS  = 8'h79;
   localparam logic [7:0] ZONE1_CORR_OFS       = 8'h7d;
   localparam logic [7:0] GEN_CFG_OFS          = 8'h40;
   localparam logic [7:0] SUPPLY_STATE_OFS     = 8'h41;
   localparam logic [7:0] CH_STAT_BASE_OFS     = 8'h43;

   // channel supply configuration field positions
   localparam int unsigned TWELVE_V_BIT   = 4;
   localparam int unsigned FIVE_V_BIT     = 3;
   localparam int unsigned THREE_V3_BIT   = 2;
   localparam int unsigned CPU_CORE_BIT   = 1;
   localparam int unsigned TWO_V5_BIT     = 0;
   localparam logic [4:0]  CHAN_SUPPLY_CFG_RST = 5'h02;

   // zone1 correction layout
   localparam int unsigned GAIN_LSB   = 6;
   localparam int unsigned GAIN_W     = 2;
   localparam int unsigned RSVD_W     = 2;
   localparam int unsigned OFFSET_W   = 4;
   localparam logic [1:0]  GAIN_RST   = 2'h0;
   localparam logic [3:0]  OFFSET_RST = 4'h0;

   // general configuration and supply state bits
   localparam int unsigned LOCK_BIT        = 0;
   localparam int unsigned SUPPLY_ON_BIT   = 0;
   localparam int unsigned SUPPLY_RDY_BIT  = 1;

   // resume delay after the main supply returns
   localparam longint RESUME_DELAY_MS = 182;
   localparam longint CLK_HZ          = 40000000;
   localparam longint RESUME_CYCLES   = (RESUME_DELAY_MS * CLK_HZ + 999) / 1000;

endpackage : sgc_pkg

// ### hdl/sgc_gate_if.sv
// supply state carried from the supply gate to the register bank
// assumes both ends sit on ref_clk
interface sgc_gate_if;
   logic supply_on;
   logic supply_ready;

   modport gate (
      output supply_on,
      output supply_ready
   );

   modport user (
      input supply_on,
      input supply_ready
   );
endinterface : sgc_gate_if

// ### hdl/sgc_supply_gate.sv
// main supply synchroniser and resume delay counter
// assumes main_supply is an asynchronous level from the power logic
module sgc_supply_gate #(
   parameter longint RESUME_CYCLES = sgc_pkg::RESUME_CYCLES,
   parameter int     CNT_W         = $clog2(RESUME_CYCLES + 1)
) (
   input  wire logic   ref_clk,
   input  wire logic   arst_n,
   input  wire logic   main_supply,
   sgc_gate_if.gate    gate
);

   localparam logic [CNT_W-1:0] LAST = CNT_W'(RESUME_CYCLES - 1);

   logic             sync1_reg;
   logic             sync2_reg;
   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] cnt_next;
   logic             ready_reg;
   logic             ready_next;
   wire              cnt_done;

   // supply loss restarts the wait at once; a glitch costs a full delay
   assign cnt_done   = (cnt_reg == LAST);
   assign cnt_next   = (!sync2_reg || ready_reg) ? '0 : cnt_reg + CNT_W'(1);
   assign ready_next = sync2_reg && (ready_reg || cnt_done);

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         cnt_reg   <= '0;
         ready_reg <= 1'b0;
      end else begin
         sync1_reg <= main_supply;
         sync2_reg <= sync1_reg;
         cnt_reg   <= cnt_next;
         ready_reg <= ready_next;
      end
   end

   assign gate.supply_on    = sync2_reg;
   assign gate.supply_ready = ready_reg;

endmodule // sgc_supply_gate

// ### hdl/sgc_top.sv
// register bank for supply-gated voltage channels and zone1 correction
// assumes raw channel status comes from monitor logic on ref_clk and that
// main_supply is an asynchronous level from the power logic
//
// The address-and-strobe port was left to the implementer.
module sgc_top #(
   parameter longint      RESUME_CYCLES = sgc_pkg::RESUME_CYCLES,
   parameter int unsigned NUM_CH        = sgc_pkg::NUM_CH,
   parameter int unsigned STAT_W        = sgc_pkg::STAT_W
) (
   input  wire logic                      ref_clk,
   input  wire logic                      arst_n,
   input  wire logic [7:0]                reg_addr,
   input  wire logic [7:0]                reg_wdata,
   input  wire logic                      reg_wr,
   input  wire logic                      reg_rd,
   output logic      [7:0]                reg_rdata,
   input  wire logic                      main_supply,
   input  wire logic [NUM_CH*STAT_W-1:0]  ch_status_raw,
   output logic      [NUM_CH-1:0]         ch_monitor_en,
   output logic      [NUM_CH*STAT_W-1:0]  ch_status,
   output logic      [sgc_pkg::GAIN_W-1:0]   zone1_gain,
   output logic      [sgc_pkg::OFFSET_W-1:0] zone1_offset,
   output logic                           cfg_locked
);

   sgc_gate_if gate_bus ();

   sgc_supply_gate #(
      .RESUME_CYCLES (RESUME_CYCLES)
   ) u_gate (
      .ref_clk     (ref_clk),
      .arst_n      (arst_n),
      .main_supply (main_supply),
      .gate        (gate_bus.gate)
   );

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------

   logic                          twelve_volt_main_supply_sel_reg;
   logic                          five_volt_main_supply_sel_reg;
   logic                          three_v3_main_supply_sel_reg;
   logic                          cpu_core_main_supply_sel_reg;
   logic                          two_v5_main_supply_sel_reg;
   logic [sgc_pkg::GAIN_W-1:0]    gain_reg;
   logic [sgc_pkg::OFFSET_W-1:0]  offset_reg;
   logic                          lock_reg;
   logic [NUM_CH-1:0]             mon_en_reg;
   logic [NUM_CH*STAT_W-1:0]      stat_reg;
   logic [7:0]                    rdata_reg;

   logic                          twelve_volt_main_supply_sel_next;
   logic                          five_volt_main_supply_sel_next;
   logic                          three_v3_main_supply_sel_next;
   logic                          cpu_core_main_supply_sel_next;
   logic                          two_v5_main_supply_sel_next;
   logic [sgc_pkg::GAIN_W-1:0]    gain_next;
   logic [sgc_pkg::OFFSET_W-1:0]  offset_next;
   logic                          lock_next;
   logic [NUM_CH-1:0]             mon_en_next;
   logic [NUM_CH*STAT_W-1:0]      stat_next;
   logic [7:0]                    rdata_next;

   // ------------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------------

   wire hit_cfg    = (reg_addr == sgc_pkg::CHAN_SUPPLY_CFG_OFS);
   wire hit_corr   = (reg_addr == sgc_pkg::ZONE1_CORR_OFS);
   wire hit_gen    = (reg_addr == sgc_pkg::GEN_CFG_OFS);
   wire hit_state  = (reg_addr == sgc_pkg::SUPPLY_STATE_OFS);

   // both configuration registers freeze together once lock is set
   wire wr_cfg     = reg_wr && hit_cfg && !lock_reg;
   wire wr_corr    = reg_wr && hit_corr && !lock_reg;
   wire wr_gen     = reg_wr && hit_gen;

   // ------------------------------------------------------------------
   // channel supply configuration, bits 7..5 are not held here
   // ------------------------------------------------------------------

   assign twelve_volt_main_supply_sel_next = wr_cfg ? reg_wdata[sgc_pkg::TWELVE_V_BIT]
                                                    : twelve_volt_main_supply_sel_reg;
   assign five_volt_main_supply_sel_next   = wr_cfg ? reg_wdata[sgc_pkg::FIVE_V_BIT]
                                                    : five_volt_main_supply_sel_reg;
   assign three_v3_main_supply_sel_next    = wr_cfg ? reg_wdata[sgc_pkg::THREE_V3_BIT]
                                                    : three_v3_main_supply_sel_reg;
   assign cpu_core_main_supply_sel_next    = wr_cfg ? reg_wdata[sgc_pkg::CPU_CORE_BIT]
                                                    : cpu_core_main_supply_sel_reg;
   assign two_v5_main_supply_sel_next      = wr_cfg ? reg_wdata[sgc_pkg::TWO_V5_BIT]
                                                    : two_v5_main_supply_sel_reg;

   // channel index follows the bit position of its select
   wire [NUM_CH-1:0] supply_sel;
   assign supply_sel[sgc_pkg::TWELVE_V_BIT] = twelve_volt_main_supply_sel_reg;
   assign supply_sel[sgc_pkg::FIVE_V_BIT]   = five_volt_main_supply_sel_reg;
   assign supply_sel[sgc_pkg::THREE_V3_BIT] = three_v3_main_supply_sel_reg;
   assign supply_sel[sgc_pkg::CPU_CORE_BIT] = cpu_core_main_supply_sel_reg;
   assign supply_sel[sgc_pkg::TWO_V5_BIT]   = two_v5_main_supply_sel_reg;

   wire [7:0] cfg_rd = {3'h0, supply_sel};

   // ------------------------------------------------------------------
   // zone1 correction
   // ------------------------------------------------------------------

   wire [sgc_pkg::GAIN_W-1:0]   wr_gain   =
      reg_wdata[sgc_pkg::GAIN_LSB +: sgc_pkg::GAIN_W];
   wire [sgc_pkg::OFFSET_W-1:0] wr_offset = reg_wdata[sgc_pkg::OFFSET_W-1:0];

   assign gain_next   = wr_corr ? wr_gain : gain_reg;
   assign offset_next = wr_corr ? wr_offset : offset_reg;

   // reserved bits are not stored and always read as zero
   wire [7:0] corr_rd = {gain_reg, {sgc_pkg::RSVD_W{1'b0}}, offset_reg};

   // ------------------------------------------------------------------
   // general configuration: lock can only be released by reset
   // ------------------------------------------------------------------

   assign lock_next = lock_reg || (wr_gen && reg_wdata[sgc_pkg::LOCK_BIT]);

   wire [7:0] gen_rd = {7'h00, lock_reg};

   // ------------------------------------------------------------------
   // per-channel gating
   // ------------------------------------------------------------------

   wire supply_on    = gate_bus.supply_on;
   wire supply_ready = gate_bus.supply_ready;

   wire [7:0] state_rd;
   assign state_rd[sgc_pkg::SUPPLY_ON_BIT]  = supply_on;
   assign state_rd[sgc_pkg::SUPPLY_RDY_BIT] = supply_ready;
   assign state_rd[7:2]                     = 6'h00;

   wire [NUM_CH-1:0] ch_held;
   wire [7:0]        ch_rd_or [NUM_CH+1];
   assign ch_rd_or[0] = 8'h00;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
         // a marked channel stays held from supply loss until the delay ends
         assign ch_held[gi] = supply_sel[gi] && !supply_ready;

         assign mon_en_next[gi] = !ch_held[gi];

         assign stat_next[gi*STAT_W +: STAT_W] =
            ch_held[gi] ? {STAT_W{1'b0}}
                        : ch_status_raw[gi*STAT_W +: STAT_W];

         // gated status readback, one register per channel
         wire hit_ch = (reg_addr == (sgc_pkg::CH_STAT_BASE_OFS + 8'(gi)));
         wire [7:0] ch_val = 8'(stat_reg[gi*STAT_W +: STAT_W]);

         assign ch_rd_or[gi+1] = ch_rd_or[gi] | (hit_ch ? ch_val : 8'h00);
      end
   endgenerate

   // ------------------------------------------------------------------
   // read path: data appear only in the cycle after the read strobe
   // ------------------------------------------------------------------

   wire [7:0] rd_val =
      hit_cfg   ? cfg_rd   :
      hit_corr  ? corr_rd  :
      hit_gen   ? gen_rd   :
      hit_state ? state_rd :
                  ch_rd_or[NUM_CH];

   assign rdata_next = reg_rd ? rd_val : 8'h00;

   // ------------------------------------------------------------------
   // registers
   // ------------------------------------------------------------------

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         twelve_volt_main_supply_sel_reg <= sgc_pkg::CHAN_SUPPLY_CFG_RST[sgc_pkg::TWELVE_V_BIT];
         five_volt_main_supply_sel_reg   <= sgc_pkg::CHAN_SUPPLY_CFG_RST[sgc_pkg::FIVE_V_BIT];
         three_v3_main_supply_sel_reg    <= sgc_pkg::CHAN_SUPPLY_CFG_RST[sgc_pkg::THREE_V3_BIT];
         cpu_core_main_supply_sel_reg    <= sgc_pkg::CHAN_SUPPLY_CFG_RST[sgc_pkg::CPU_CORE_BIT];
         two_v5_main_supply_sel_reg      <= sgc_pkg::CHAN_SUPPLY_CFG_RST[sgc_pkg::TWO_V5_BIT];
      end else begin
         twelve_volt_main_supply_sel_reg <= twelve_volt_main_supply_sel_next;
         five_volt_main_supply_sel_reg   <= five_volt_main_supply_sel_next;
         three_v3_main_supply_sel_reg    <= three_v3_main_supply_sel_next;
         cpu_core_main_supply_sel_reg    <= cpu_core_main_supply_sel_next;
         two_v5_main_supply_sel_reg      <= two_v5_main_supply_sel_next;
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         gain_reg   <= sgc_pkg::GAIN_RST;
         offset_reg <= sgc_pkg::OFFSET_RST;
         lock_reg   <= 1'b0;
      end else begin
         gain_reg   <= gain_next;
         offset_reg <= offset_next;
         lock_reg   <= lock_next;
      end
   end

   // marked channels start held: supply_ready stays low until the resume delay ends
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         mon_en_reg <= ~sgc_pkg::CHAN_SUPPLY_CFG_RST;
         stat_reg   <= '0;
         rdata_reg  <= 8'h00;
      end else begin
         mon_en_reg <= mon_en_next;
         stat_reg   <= stat_next;
         rdata_reg  <= rdata_next;
      end
   end

   // ------------------------------------------------------------------
   // outputs, all straight from flip-flops
   // ------------------------------------------------------------------

   assign reg_rdata     = rdata_reg;
   assign ch_monitor_en = mon_en_reg;
   assign ch_status     = stat_reg;
   assign zone1_gain    = gain_reg;
   assign zone1_offset  = offset_reg;
   assign cfg_locked    = lock_reg;

endmodule // sgc_top

// ### test/sgc_checker.sv
// concurrent checks on the ports of sgc_top
// assumes one ref_clk domain with arst_n as asynchronous active-low reset
module sgc_checker #(
   parameter longint      RESUME_CYCLES = sgc_pkg::RESUME_CYCLES,
   parameter int unsigned NUM_CH        = sgc_pkg::NUM_CH,
   parameter int unsigned STAT_W        = sgc_pkg::STAT_W
) (
   input wire logic                         ref_clk,
   input wire logic                         arst_n,
   input wire logic [7:0]                   reg_addr,
   input wire logic [7:0]                   reg_wdata,
   input wire logic                         reg_wr,
   input wire logic                         reg_rd,
   input wire logic [7:0]                   reg_rdata,
   input wire logic                         main_supply,
   input wire logic [NUM_CH*STAT_W-1:0]     ch_status_raw,
   input wire logic [NUM_CH-1:0]            ch_monitor_en,
   input wire logic [NUM_CH*STAT_W-1:0]     ch_status,
   input wire logic [sgc_pkg::GAIN_W-1:0]   zone1_gain,
   input wire logic [sgc_pkg::OFFSET_W-1:0] zone1_offset,
   input wire logic                         cfg_locked
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);

   logic [NUM_CH*STAT_W-1:0] en_x;
   logic [7:0]               wdata_reg;
   int unsigned              on_cnt_reg;

   always_comb begin
      for (int i = 0; i < NUM_CH*STAT_W; i++) begin
         en_x[i] = ch_monitor_en[i/STAT_W];
      end
   end

   // saturating count of cycles with the supply pin continuously high
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         on_cnt_reg <= 0;
         wdata_reg  <= 8'h00;
      end else begin
         wdata_reg  <= reg_wdata;
         on_cnt_reg <= !main_supply ? 0 : (on_cnt_reg < 1000 ? on_cnt_reg + 1 : on_cnt_reg);
      end
   end

   rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("read data not zero outside read answer");
   corr_read_a: assert property (reg_rd && reg_addr == 8'h7d |=>
      reg_rdata == {zone1_gain, 2'h0, zone1_offset}) else $error("correction read mismatch");
   corr_write_a: assert property (reg_wr && reg_addr == 8'h7d && !cfg_locked |=>
      {zone1_gain, zone1_offset} == {wdata_reg[7:6], wdata_reg[3:0]})
      else $error("correction write not applied");
   corr_lock_a: assert property (cfg_locked && reg_wr && reg_addr == 8'h7d |=>
      $stable(zone1_gain) && $stable(zone1_offset)) else $error("locked correction changed");
   lock_sticky_a: assert property (cfg_locked |=> cfg_locked)
      else $error("lock bit cleared");
   gated_zero_a: assert property ((ch_status & ~en_x) == '0)
      else $error("status of stopped channel not zero");
   resume_en_a: assert property (on_cnt_reg >= RESUME_CYCLES + 6 |->
      ch_monitor_en == '1) else $error("channel not resumed after delay");
   resume_status_a: assert property (on_cnt_reg >= RESUME_CYCLES + 6 |->
      ch_status == $past(ch_status_raw)) else $error("status not following raw");
endmodule : sgc_checker

bind sgc_top sgc_checker #(.RESUME_CYCLES(RESUME_CYCLES), .NUM_CH(NUM_CH), .STAT_W(STAT_W)) u_chk (
   .ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .main_supply(main_supply),
   .ch_status_raw(ch_status_raw), .ch_monitor_en(ch_monitor_en), .ch_status(ch_status),
   .zone1_gain(zone1_gain), .zone1_offset(zone1_offset), .cfg_locked(cfg_locked));

// ### test/sgc_tb_top.sv
// self-checking bench for sgc_top, driving every port directly
// assumes a short resume delay parameter so gating completes quickly
module sgc_tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   localparam longint RC = 20;

   logic        ref_clk = 1'b0;
   logic        arst_n = 1'b0;
   logic [7:0]  reg_addr = 8'h00;
   logic [7:0]  reg_wdata = 8'h00;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [7:0]  reg_rdata;
   logic        main_supply = 1'b1;
   logic [19:0] ch_status_raw = 20'h9a5c3;
   logic [4:0]  ch_monitor_en;
   logic [19:0] ch_status;
   logic [1:0]  zone1_gain;
   logic [3:0]  zone1_offset;
   logic        cfg_locked;
   int          fail_count = 0;
   int          n_tests = 0;
   logic [7:0]  rd_val;

`define CHK(name, exp, got) begin \
   n_tests++; \
   if ((got) !== (exp)) begin \
      fail_count++; \
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got); \
   end \
end

   sgc_top #(.RESUME_CYCLES(RC)) dut (
      .ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .main_supply(main_supply),
      .ch_status_raw(ch_status_raw), .ch_monitor_en(ch_monitor_en), .ch_status(ch_status),
      .zone1_gain(zone1_gain), .zone1_offset(zone1_offset), .cfg_locked(cfg_locked));

   initial begin
      forever #12.5 ref_clk = ~ref_clk;
   end

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask

   // data is taken one step after the answer edge so the register has landed
   task automatic rd(input logic [7:0] a);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 rd_val = reg_rdata;
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   task automatic t_reset_values();
      rd(8'h79);
      `CHK("supply cfg reset", 8'h02, rd_val)
      // resume delay still running: only the core channel is marked and held
      `CHK("enable after reset", 5'h1d, ch_monitor_en)
      `CHK("status after reset", 20'h9a503, ch_status)
      rd(8'h7d);
      `CHK("correction reset", 8'h00, rd_val)
      rd(8'h7e);
      `CHK("unmapped read", 8'h00, rd_val)
   endtask

   task automatic t_select_bits();
      for (int i = 0; i < 5; i++) begin
         wr(8'h79, 8'h01 << i);
         rd(8'h79);
         `CHK("supply select bit", 8'h01 << i, rd_val)
      end
   endtask

   task automatic t_correction();
      wr(8'h7d, 8'hff);
      rd(8'h7d);
      `CHK("correction readback", 8'hcf, rd_val)
      `CHK("gain field", 2'h3, zone1_gain)
      `CHK("offset field", 4'hf, zone1_offset)
   endtask

   // 12V, 3.3V and 2.5V marked; 5V and CPU core left free
   task automatic t_gating();
      wr(8'h79, 8'h15);
      wait_cyc(RC + 8);
      `CHK("enable with supply on", 5'h1f, ch_monitor_en)
      @(posedge ref_clk);
      main_supply <= 1'b0;
      wait_cyc(5);
      `CHK("enable supply off", 5'h0a, ch_monitor_en)
      `CHK("status supply off", ch_status_raw & 20'h0f0f0, ch_status)
      rd(8'h41);
      `CHK("supply state off", 8'h00, rd_val)
      rd(8'h43);
      `CHK("held channel readback", 8'h00, rd_val)
      rd(8'h44);
      `CHK("free channel readback", 8'h0c, rd_val)
      @(posedge ref_clk);
      main_supply <= 1'b1;
      wait_cyc(RC);
      `CHK("enable during delay", 5'h0a, ch_monitor_en)
      wait_cyc(6);
      `CHK("enable after delay", 5'h1f, ch_monitor_en)
      `CHK("status after delay", ch_status_raw, ch_status)
      rd(8'h41);
      `CHK("supply state on", 8'h03, rd_val)
      rd(8'h47);
      `CHK("released channel readback", 8'h09, rd_val)
   endtask

   task automatic t_lock();
      wr(8'h40, 8'h01);
      wait_cyc(1);
      `CHK("lock set", 1'b1, cfg_locked)
      wr(8'h7d, 8'h00);
      rd(8'h7d);
      `CHK("locked correction", 8'hcf, rd_val)
      wr(8'h79, 8'h00);
      rd(8'h79);
      `CHK("locked supply cfg", 8'h15, rd_val)
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // whole run is about 120 cycles; the 4000-cycle limit leaves ample margin
   initial begin
      #(25 * 4000);
      fail_count++;
      results();
   end

   initial begin
      repeat (4) @(posedge ref_clk);
      arst_n <= 1'b1;
      t_reset_values();
      t_select_bits();
      t_correction();
      t_gating();
      t_lock();
      results();
   end
endmodule : sgc_tb_top
